// File: inc/ppcd_defines.svh
// Register offsets, field positions, reset values and masks of the pin-change detector
`ifndef PPCD_DEFINES_SVH
`define PPCD_DEFINES_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PPCD_OFF_PORT_A_VALUE 8'h00
`define PPCD_OFF_PORT_B_VALUE 8'h04
`define PPCD_OFF_PORT_A_CHANGE_ENABLE 8'h08
`define PPCD_OFF_PORT_B_CHANGE_ENABLE 8'h0c
`define PPCD_OFF_INTERRUPT_CONTROL 8'h10
`define PPCD_OFF_CONFIG 8'h14
// ----------------------------------------
// Implemented-bit masks and reset values
// ----------------------------------------
`define PPCD_PORT_A_MASK 8'hef
`define PPCD_PORT_B_MASK 8'hf3
`define PPCD_ENABLE_RESET 8'h00
`define PPCD_INTCTL_RESET 8'h00
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PPCD_INTCTL_FLAG_BIT 0
`define PPCD_INTCTL_IE_BIT 3
`define PPCD_CFG_EXTRST_BIT 0
`define PPCD_CFG_SLEEP_BIT 1
`define PPCD_PIN_A_FIVE 5
`endif

// File: inc/ppcd_pkg.sv
// Types shared by the pin-change detector
package ppcd_pkg;
  typedef enum logic [1:0] {
    PPCD_ADDR = 2'b00,
    PPCD_DATA = 2'b01
  } ppcd_phase_t;
  typedef logic [7:0] ppcd_byte_t;
endpackage

// File: rtl/ppcd_port_pin_change_detector.sv
// Pin-change detector for two general-purpose ports with an AHB-Lite register slave
//
// Notes on behaviour
// - Port A has change enables at bits 7, 6, 5 and 3..0; bit 4 reads zero; all reset to zero.
// - Port B has change enables at bits 7..4 and 1..0; bits 3..2 read zero; all reset to zero.
// - Port A pin five is never watched while it serves as the external reset input.
// - While any watched pin mismatches its latch the flag keeps being set, so a clear fails.
// - Reading either port reloads the compare latch from the pins, ending the mismatch.
// - Writing either port also reloads the latch and ends the mismatch.
// - The compare latch survives the external-pin reset, so a held mismatch sets the flag again.
// - A watched pin change in the same cycle as a port access still sets the flag, at the same edge as the latch reload.
// - With the change-interrupt enable set, a detected change raises a wake request in sleep.
// - Each watched pin is compared with its latch and all mismatches are ORed into one flag.
// - The flag sets whatever the interrupt enable, but the interrupt needs the enable.
// - Power-on reset leaves every change enable cleared.
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
`include "ppcd_defines.svh"

module ppcd_port_pin_change_detector (
  // Clock and power-on reset
  input wire logic hclk,
  input wire logic hresetn,
  // External-pin reset, synchronous active-low pulse
  input wire logic ext_reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Port pins
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] port_b_pins,
  // Events
  output logic irq,
  output logic wake
);

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  ppcd_pkg::ppcd_byte_t sync_a1, sync_a2, sync_b1, sync_b2;
  // Only the second stage is read: the first may still be settling
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_a1 <= 8'h00;
      sync_a2 <= 8'h00;
    end else begin
      sync_a1 <= port_a_pins;
      sync_a2 <= sync_a1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_b1 <= 8'h00;
      sync_b2 <= 8'h00;
    end else begin
      sync_b1 <= port_b_pins;
      sync_b2 <= sync_b1;
    end
  end

  // ----------------------------------------
  // Bus address phase capture
  // ----------------------------------------
  logic dp_write;
  logic [7:0] dp_addr;
  // A data phase follows every taken transfer, back to back included
  ppcd_pkg::ppcd_phase_t phase;
  wire logic take = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      phase <= ppcd_pkg::PPCD_ADDR;
    end else begin
      if (take) begin
        dp_write <= hwrite;
        dp_addr <= haddr;
      end
      case (phase)
        ppcd_pkg::PPCD_ADDR: phase <= take ? ppcd_pkg::PPCD_DATA : ppcd_pkg::PPCD_ADDR;
        ppcd_pkg::PPCD_DATA: phase <= take ? ppcd_pkg::PPCD_DATA : ppcd_pkg::PPCD_ADDR;
        default: phase <= ppcd_pkg::PPCD_ADDR;
      endcase
    end
  end

  // A write lands in its data phase, when hwdata stands
  wire logic wr = (phase == ppcd_pkg::PPCD_DATA) && dp_write;
  wire logic rd_take = take && !hwrite;
  // Registers are one byte wide; upper write data bits are ignored
  wire logic [7:0] wbyte = hwdata[7:0];
  // Port reads reload the latch at the address phase, port writes at the data phase
  wire logic port_rd = rd_take && (haddr == `PPCD_OFF_PORT_A_VALUE || haddr == `PPCD_OFF_PORT_B_VALUE);
  wire logic port_wr = wr && (dp_addr == `PPCD_OFF_PORT_A_VALUE || dp_addr == `PPCD_OFF_PORT_B_VALUE);

  // Register selects of the write data phase
  wire logic wr_en_a = wr && dp_addr == `PPCD_OFF_PORT_A_CHANGE_ENABLE;
  wire logic wr_en_b = wr && dp_addr == `PPCD_OFF_PORT_B_CHANGE_ENABLE;
  wire logic wr_intctl = wr && dp_addr == `PPCD_OFF_INTERRUPT_CONTROL;
  wire logic wr_config = wr && dp_addr == `PPCD_OFF_CONFIG;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  ppcd_pkg::ppcd_byte_t port_a_change_enable, port_b_change_enable;
  logic pin_change_int_enable;
  logic ext_reset_sel;
  logic sleeping;

  // Unimplemented enable bits are never stored, so they read back zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_a_change_enable <= `PPCD_ENABLE_RESET;
    end else if (!ext_reset_n) begin
      port_a_change_enable <= `PPCD_ENABLE_RESET;
    end else if (wr_en_a) begin
      port_a_change_enable <= wbyte & `PPCD_PORT_A_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_b_change_enable <= `PPCD_ENABLE_RESET;
    end else if (!ext_reset_n) begin
      port_b_change_enable <= `PPCD_ENABLE_RESET;
    end else if (wr_en_b) begin
      port_b_change_enable <= wbyte & `PPCD_PORT_B_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_change_int_enable <= 1'b0;
    end else if (!ext_reset_n) begin
      pin_change_int_enable <= 1'b0;
    end else if (wr_intctl) begin
      pin_change_int_enable <= wbyte[`PPCD_INTCTL_IE_BIT];
    end
  end

  // The reset-pin choice is configuration and survives the external-pin reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_reset_sel <= 1'b0;
    end else if (ext_reset_n && wr_config) begin
      ext_reset_sel <= wbyte[`PPCD_CFG_EXTRST_BIT];
    end
  end

  // Sleep ends on the wake pulse; a config write in the same cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleeping <= 1'b0;
    end else if (!ext_reset_n) begin
      sleeping <= 1'b0;
    end else if (wr_config) begin
      sleeping <= wbyte[`PPCD_CFG_SLEEP_BIT];
    end else if (wake) begin
      sleeping <= 1'b0;
    end
  end

  // ----------------------------------------
  // Compare latch and mismatch
  // ----------------------------------------
  // Latch has only the power-on reset: external reset leaves it alone on purpose
  ppcd_pkg::ppcd_byte_t latch_a, latch_b;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_a <= 8'h00;
      latch_b <= 8'h00;
    end else if (port_rd || port_wr) begin
      // A change seen in this same cycle still sets the flag at this edge, as the latch takes it
      latch_a <= sync_a2;
      latch_b <= sync_b2;
    end
  end

  ppcd_pkg::ppcd_byte_t watch_a;
  logic [15:0] pins_now;
  logic [15:0] pins_last;
  logic [15:0] watch;
  logic [15:0] diff;

  always_comb begin
    watch_a = port_a_change_enable & `PPCD_PORT_A_MASK;
    if (ext_reset_sel) begin
      watch_a[`PPCD_PIN_A_FIVE] = 1'b0;
    end
  end

  // Port A on the upper byte and port B on the lower, so one loop serves both ports
  assign pins_now = {sync_a2, sync_b2};
  assign pins_last = {latch_a, latch_b};
  assign watch = {watch_a, port_b_change_enable & `PPCD_PORT_B_MASK};

  for (genvar i = 0; i < 16; i++) begin : g_pin
    assign diff[i] = watch[i] && (pins_now[i] != pins_last[i]);
  end

  wire logic mismatch = |diff;

  // ----------------------------------------
  // Change flag, interrupt and wake
  // ----------------------------------------
  logic pin_change_flag;
  logic next_pin_change_flag;
  wire logic flag_clr = wr_intctl && wbyte[`PPCD_INTCTL_FLAG_BIT];

  // Set beats clear, so a clear issued while a mismatch stands has no effect
  always_comb begin
    next_pin_change_flag = pin_change_flag;
    if (flag_clr || !ext_reset_n) begin
      next_pin_change_flag = 1'b0;
    end
    if (mismatch) begin
      next_pin_change_flag = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_change_flag <= 1'b0;
    end else begin
      pin_change_flag <= next_pin_change_flag;
    end
  end

  // Interrupt level follows the flag one cycle later, only with its enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= pin_change_flag && pin_change_int_enable;
    end
  end

  // Wake is one pulse: its own echo blocks a second one while sleep is being left
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake <= 1'b0;
    end else begin
      wake <= sleeping && pin_change_flag && pin_change_int_enable && !wake;
    end
  end

  // ----------------------------------------
  // Read data and response
  // ----------------------------------------
  logic [31:0] next_hrdata;

  // Read data are picked at the address phase and stand until the next read
  always_comb begin
    next_hrdata = hrdata;
    if (rd_take) begin
      case (haddr)
        `PPCD_OFF_PORT_A_VALUE: next_hrdata = {24'h000000, sync_a2 & `PPCD_PORT_A_MASK};
        `PPCD_OFF_PORT_B_VALUE: next_hrdata = {24'h000000, sync_b2 & `PPCD_PORT_B_MASK};
        `PPCD_OFF_PORT_A_CHANGE_ENABLE: next_hrdata = {24'h000000, port_a_change_enable};
        `PPCD_OFF_PORT_B_CHANGE_ENABLE: next_hrdata = {24'h000000, port_b_change_enable};
        `PPCD_OFF_INTERRUPT_CONTROL: next_hrdata = {28'h0000000, pin_change_int_enable, 2'b00, pin_change_flag};
        `PPCD_OFF_CONFIG: next_hrdata = {30'h00000000, sleeping, ext_reset_sel};
        default: next_hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else begin
      hrdata <= next_hrdata;
    end
  end

  // Zero wait states and OKAY only: no register access can fail
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

endmodule

// File: testbench/ppcd_pins.sv
// Behavioural source of the external levels on both ports
`timescale 1ns/1ns
module ppcd_pins (
  // Levels asked for by the bench
  input wire logic [7:0] want_a,
  input wire logic [7:0] want_b,
  // Port pins
  output logic [7:0] port_a_pins,
  output logic [7:0] port_b_pins
);
  // Odd delays put pin edges off the clock grid, so they really are asynchronous
  assign #37 port_a_pins = want_a;
  assign #61 port_b_pins = want_b;
endmodule

// File: testbench/ppcd_port_pin_change_detector_tb_top.sv
// Bench of the pin-change detector
`timescale 1ns/1ns
module ppcd_port_pin_change_detector_tb_top;
  logic hclk = 0, hresetn = 0, ext_reset_n = 1, hsel = 0, hwrite = 0, hreadyout, hresp, irq, wake;
  logic [7:0] haddr = 0, want_a = 0, want_b = 0, port_a_pins, port_b_pins;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 0, hrdata, q;
  logic [23:0] rows [4] = '{24'h08ffef, 24'h0cfff3, 24'h100808, 24'h18ff00};
  int num_errors = 0, n_tests = 0;
  initial begin
    forever #50 hclk = ~hclk;
  end
  ppcd_port_pin_change_detector dut (.hclk(hclk), .hresetn(hresetn), .ext_reset_n(ext_reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_a_pins(port_a_pins),
    .port_b_pins(port_b_pins), .irq(irq), .wake(wake));
  ppcd_pins pins (.want_a(want_a), .want_b(want_b), .port_a_pins(port_a_pins), .port_b_pins(port_b_pins));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    check(q, e);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h08, 0);
    rd(8'h0c, 0);
    check({hreadyout, hresp}, 2'h2);
    $display("reset test done");
    foreach (rows[i]) begin
      bus(rows[i][23:16], 1'b1, {24'h0, rows[i][15:8]});
      rd(rows[i][23:16], {24'h0, rows[i][7:0]});
    end
    $display("register rows done");
    bus(8'h10, 1'b1, 0);
    bus(8'h08, 1'b1, 1);
    rd(8'h00, 0);
    // Pin moves well clear of any port access
    want_a <= 8'h01;
    repeat (6) @(posedge hclk);
    rd(8'h10, 1);
    check(irq, 0);
    bus(8'h10, 1'b1, 1);
    rd(8'h10, 1);
    rd(8'h00, 1);
    bus(8'h10, 1'b1, 1);
    rd(8'h10, 0);
    $display("masked flag test done");
    bus(8'h0c, 1'b1, 8'h80);
    bus(8'h10, 1'b1, 8'h08);
    bus(8'h14, 1'b1, 8'h02);
    want_b <= 8'h80;
    for (int i = 0; i < 20 && wake !== 1'b1; i++) @(posedge hclk);
    check(wake, 1);
    check(irq, 1);
    bus(8'h04, 1'b1, 0);
    bus(8'h10, 1'b1, 8'h09);
    repeat (3) @(posedge hclk);
    check(irq, 0);
    $display("wake test done");
    bus(8'h14, 1'b1, 1);
    bus(8'h08, 1'b1, 8'h20);
    rd(8'h00, 8'h01);
    want_a <= 8'h21;
    repeat (6) @(posedge hclk);
    rd(8'h10, 8'h08);
    $display("reset pin test done");
    bus(8'h14, 1'b1, 0);
    bus(8'h08, 1'b1, 1);
    want_a <= 8'h20;
    repeat (6) @(posedge hclk);
    ext_reset_n <= 1'b0;
    @(posedge hclk);
    ext_reset_n <= 1'b1;
    rd(8'h08, 0);
    check(irq, 0);
    // Clear the stale flag first, so only the retained latch can set it again
    bus(8'h10, 1'b1, 1);
    rd(8'h10, 0);
    bus(8'h08, 1'b1, 1);
    repeat (6) @(posedge hclk);
    rd(8'h10, 1);
    $display("latch retention test done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h08, 0);
    rd(8'h10, 0);
    rd(8'h00, 8'h20);
    $display("second reset test done");
    finish_test();
  end
endmodule
bind ppcd_port_pin_change_detector ppcd_chk chk (.hclk(hclk), .hresetn(hresetn), .ext_reset_n(ext_reset_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .port_a_pins(port_a_pins), .irq(irq), .wake(wake));

// File: testbench/ppcd_sva.sv
// Port assertions of the pin-change detector
`timescale 1ns/1ns
module ppcd_chk (
  // Clock and resets
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ext_reset_n,
  // Bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Pins and events
  input wire logic [7:0] port_a_pins,
  input wire logic irq,
  input wire logic wake
);
  logic rd_q;
  logic [7:0] a_q;
  logic [3:0] hist;
  wire take = hsel && hready && htrans[1];
  // Recent causes that may legally drop the interrupt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      a_q <= 8'h00;
      hist <= 4'h0;
    end else begin
      rd_q <= take && !hwrite;
      a_q <= haddr;
      hist <= {hist[2:0], (take && hwrite && haddr == 8'h10) || !ext_reset_n};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_gap_a: assert property (rd_q && a_q == 8'h08 |-> !hrdata[4]) else $error("port a gap set");
  b_gap_a: assert property (rd_q && a_q == 8'h0c |-> hrdata[3:2] == 2'h0) else $error("port b gap set");
  upper_zero_a: assert property (rd_q |-> hrdata[31:8] == 24'h0) else $error("upper bits set");
  irq_fall_a: assert property ($fell(irq) |-> |hist) else $error("irq fell alone");
  wake_irq_a: assert property (wake |-> irq) else $error("wake without irq");
  wake_pulse_a: assert property (wake |=> !wake) else $error("wake too long");
  pin_sync_a: assert property (!irq && $changed(port_a_pins) |=> !irq [*2]) else $error("pin not synced");
  ext_quiet_a: assert property (!ext_reset_n |-> ##2 !irq) else $error("irq after ext reset");
  cover property (wake);
  cover property ($fell(irq));
  cover property (rd_q && a_q == 8'h00);
endmodule
